// [design/port_wake_and_irq_regs.sv]
`timescale 1ns/1ps
// How it works
// - class 1 tag low byte holds VID bits 7:0, read/write, resets to 0x02.
// - class 2 tag high byte: priority 7:5, CFI 4, VID 11:8; resets 0x40.
// - class 2 tag low byte holds VID bits 7:0, read/write, resets to 0x03.
// - wake bit 2 latches on magic packet matching the switch MAC address.
// - wake bit 1 latches on link up; only PHY ports use it.
// - wake bit 0 latches on cable energy; only PHY ports use it.
// - magic enable bit gates magic detection onto the power event pin.
// - link-up enable bit gates link-up detection onto the power event pin.
// - energy enable bit gates energy detection onto the power event pin.
// - summary bit 2 follows pending PTP interrupts; zero on the MAC port.
// - summary bit 1 follows pending PHY interrupts on PHY ports.
// - summary bit 0 sets when a counter-mode ACL entry interrupts.
// - ACL status ignores writes; toggling its mask bit clears it.
// - each summary source is forwarded only while its mask bit is zero.
module port_wake_and_irq_regs (
  input wire logic clk_sys,
  input wire logic srst,
  input wire port_regs_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire port_regs_pkg::port_ev_s [port_regs_pkg::NUM_PORTS-1:0] port_ev,
  output logic [port_regs_pkg::NUM_PORTS-1:0] port_irq,
  output logic power_event_pin,
  output logic irq
);

  localparam int NP = port_regs_pkg::NUM_PORTS;

  // per-port read value, forwarded interrupt and power event request
  logic [NP-1:0][7:0] port_rd;
  logic [NP-1:0] port_sel;
  logic [NP-1:0] port_fwd;
  logic [NP-1:0] port_pwr;

  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic [NP-1:0] port_irq_q;
  logic power_event_q;

  // block interrupt registers
  logic [3:0] blk_stat_q;
  logic [3:0] blk_en_q;
  logic [3:0] blk_event;
  logic pwr_rise;
  logic [NP-1:0] fwd_rise;
  logic blk_clr_hit;
  logic blk_en_hit;
  logic irq_q;

  // address fields and global page decode
  logic glb_sel;
  logic [3:0] addr_port;
  logic [3:0] addr_page;
  logic [7:0] ofs;

  // a nonzero page nibble selects nothing, so the upper map reads zero
  assign addr_port = req.addr[port_regs_pkg::PORT_LSB +: 4];
  assign addr_page = req.addr[port_regs_pkg::PAGE_LSB +: 4];
  assign ofs = req.addr[port_regs_pkg::OFS_LSB +: 8];
  assign glb_sel = (addr_port == port_regs_pkg::GLOBAL_PORT) &&
                   (addr_page == port_regs_pkg::PAGE_ZERO);

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_port
      // port N sits at 0xN000, N = index + 1
      localparam logic [3:0] PORT_NUM = 4'(gi + 1);
      // only ports with an integrated PHY see PHY and PTP sources
      localparam logic HAS_PHY = (gi != port_regs_pkg::MAC_PORT_IDX);

      logic sel;
      logic wr_hit;
      logic [7:0] c1_tag_low_q;
      logic [7:0] c2_tag_high_q;
      logic [7:0] c2_tag_low_q;
      logic [15:0] c1_type_q;
      logic [15:0] c2_type_q;
      logic [2:0] wake_latch_q;
      logic [2:0] wake_latch_d;
      logic [2:0] wake_enable_q;
      logic [2:0] wake_det;
      logic [2:0] wake_clr;
      logic [2:0] mask_q;
      logic acl_stat_q;
      logic acl_toggle;
      logic [2:0] summary;

      assign sel = (addr_port == PORT_NUM) &&
                   (addr_page == port_regs_pkg::PAGE_ZERO);
      assign wr_hit = req.wr && sel;
      assign port_sel[gi] = sel;

      // stream reservation tags, plain read/write storage
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          c1_tag_low_q <= port_regs_pkg::RST_C1_TAG_LOW;
          c2_tag_high_q <= port_regs_pkg::RST_C2_TAG_HIGH;
          c2_tag_low_q <= port_regs_pkg::RST_C2_TAG_LOW;
        end
        else if (wr_hit)
        begin
          if (ofs == port_regs_pkg::OFS_C1_TAG_LOW)
          begin
            c1_tag_low_q <= req.wdata;
          end
          if (ofs == port_regs_pkg::OFS_C2_TAG_HIGH)
          begin
            c2_tag_high_q <= req.wdata;
          end
          if (ofs == port_regs_pkg::OFS_C2_TAG_LOW)
          begin
            c2_tag_low_q <= req.wdata;
          end
        end
      end

      // ethertypes: high byte at the even address, low byte at the odd one
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          c1_type_q <= port_regs_pkg::RST_ETHERTYPE;
          c2_type_q <= port_regs_pkg::RST_ETHERTYPE;
        end
        else if (wr_hit)
        begin
          if (ofs == port_regs_pkg::OFS_C1_TYPE_HI)
          begin
            c1_type_q[15:8] <= req.wdata;
          end
          if (ofs == port_regs_pkg::OFS_C1_TYPE_LO)
          begin
            c1_type_q[7:0] <= req.wdata;
          end
          if (ofs == port_regs_pkg::OFS_C2_TYPE_HI)
          begin
            c2_type_q[15:8] <= req.wdata;
          end
          if (ofs == port_regs_pkg::OFS_C2_TYPE_LO)
          begin
            c2_type_q[7:0] <= req.wdata;
          end
        end
      end

      // detections; link and energy are dead on the MAC port
      always_comb
      begin
        wake_det = '0;
        wake_det[port_regs_pkg::WAKE_MAGIC_BIT] = port_ev[gi].magic_det;
        wake_det[port_regs_pkg::WAKE_LINK_BIT] =
          port_ev[gi].link_up_det && HAS_PHY;
        wake_det[port_regs_pkg::WAKE_ENERGY_BIT] =
          port_ev[gi].energy_det && HAS_PHY;
      end

      // write-one-to-clear; a detection in the same cycle wins
      assign wake_clr = (wr_hit && ofs == port_regs_pkg::OFS_WAKE_LATCH) ?
                        req.wdata[2:0] : port_regs_pkg::RST_FIELD3;
      assign wake_latch_d = (wake_latch_q & ~wake_clr) | wake_det;

      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          wake_latch_q <= port_regs_pkg::RST_FIELD3;
        end
        else
        begin
          wake_latch_q <= wake_latch_d;
        end
      end

      // wake enables, read/write
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          wake_enable_q <= port_regs_pkg::RST_FIELD3;
        end
        else if (wr_hit && ofs == port_regs_pkg::OFS_WAKE_ENABLE)
        begin
          wake_enable_q <= req.wdata[2:0];
        end
      end

      // pin request holds while an enabled latch bit stays set
      assign port_pwr[gi] = |(wake_latch_q & wake_enable_q);

      // toggle of the ACL mask bit is the only way to clear ACL status
      assign acl_toggle = wr_hit && (ofs == port_regs_pkg::OFS_IRQ_MASK) &&
        (req.wdata[port_regs_pkg::IRQ_ACL_BIT] !=
         mask_q[port_regs_pkg::IRQ_ACL_BIT]);

      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          mask_q <= port_regs_pkg::RST_FIELD3;
        end
        else if (wr_hit && ofs == port_regs_pkg::OFS_IRQ_MASK)
        begin
          mask_q <= req.wdata[2:0];
        end
      end

      // ACL status: set wins over a toggle in the same cycle
      always_ff @(posedge clk_sys)
      begin
        if (srst)
        begin
          acl_stat_q <= 1'b0;
        end
        else
        begin
          acl_stat_q <= port_ev[gi].acl_hit ||
                        (acl_stat_q && !acl_toggle);
        end
      end

      // PTP and PHY bits mirror the pending levels of the sources
      always_comb
      begin
        summary = '0;
        summary[port_regs_pkg::IRQ_PTP_BIT] =
          port_ev[gi].ptp_pending && HAS_PHY;
        summary[port_regs_pkg::IRQ_PHY_BIT] =
          port_ev[gi].phy_pending && HAS_PHY;
        summary[port_regs_pkg::IRQ_ACL_BIT] = acl_stat_q;
      end

      // mask bit of one disables its source
      assign port_fwd[gi] = |(summary & ~mask_q);

      // read value of this slice; reserved bits read as zero
      always_comb
      begin
        port_rd[gi] = port_regs_pkg::RD_ZERO;
        unique case (ofs)
          port_regs_pkg::OFS_C1_TAG_LOW: port_rd[gi] = c1_tag_low_q;
          port_regs_pkg::OFS_C2_TAG_HIGH: port_rd[gi] = c2_tag_high_q;
          port_regs_pkg::OFS_C2_TAG_LOW: port_rd[gi] = c2_tag_low_q;
          port_regs_pkg::OFS_C1_TYPE_HI: port_rd[gi] = c1_type_q[15:8];
          port_regs_pkg::OFS_C1_TYPE_LO: port_rd[gi] = c1_type_q[7:0];
          port_regs_pkg::OFS_C2_TYPE_HI: port_rd[gi] = c2_type_q[15:8];
          port_regs_pkg::OFS_C2_TYPE_LO: port_rd[gi] = c2_type_q[7:0];
          port_regs_pkg::OFS_WAKE_LATCH:
            port_rd[gi] = {5'h00, wake_latch_q};
          port_regs_pkg::OFS_WAKE_ENABLE:
            port_rd[gi] = {5'h00, wake_enable_q};
          port_regs_pkg::OFS_IRQ_SUMMARY:
            port_rd[gi] = {5'h00, summary};
          port_regs_pkg::OFS_IRQ_MASK: port_rd[gi] = {5'h00, mask_q};
          default: port_rd[gi] = port_regs_pkg::RD_ZERO;
        endcase
      end
    end
  endgenerate

  // registered level outputs; one cycle later than the status they follow
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      port_irq_q <= '0;
      power_event_q <= 1'b0;
    end
    else
    begin
      port_irq_q <= port_fwd;
      power_event_q <= |port_pwr;
    end
  end

  // rising edges of the forwarded lines feed the sticky block status;
  // the registered copies reset low like the lines, so reset adds no edge
  assign pwr_rise = |port_pwr && !power_event_q;
  assign fwd_rise = port_fwd & ~port_irq_q;
  assign blk_event = {pwr_rise, fwd_rise};

  // block register write hits in the global page
  assign blk_clr_hit = req.wr && glb_sel &&
                       (ofs == port_regs_pkg::OFS_BLK_CLEAR);
  assign blk_en_hit = req.wr && glb_sel &&
                      (ofs == port_regs_pkg::OFS_BLK_ENABLE);

  // sticky status; a new event beats a clear written in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      blk_stat_q <= port_regs_pkg::RST_FIELD4;
    end
    else if (blk_clr_hit)
    begin
      blk_stat_q <= (blk_stat_q & ~req.wdata[3:0]) | blk_event;
    end
    else
    begin
      blk_stat_q <= blk_stat_q | blk_event;
    end
  end

  // block interrupt enables
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      blk_en_q <= port_regs_pkg::RST_FIELD4;
    end
    else if (blk_en_hit)
    begin
      blk_en_q <= req.wdata[3:0];
    end
  end

  // interrupt follows status one cycle later, from a flop
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(blk_stat_q & blk_en_q);
    end
  end

  // read select; unmapped addresses and the clear register read zero
  always_comb
  begin
    rd_mux = port_regs_pkg::RD_ZERO;
    for (int i = 0; i < NP; i++)
    begin
      if (port_sel[i])
      begin
        rd_mux = port_rd[i];
      end
    end
    if (glb_sel && ofs == port_regs_pkg::OFS_BLK_STATUS)
    begin
      rd_mux = {4'h0, blk_stat_q};
    end
    if (glb_sel && ofs == port_regs_pkg::OFS_BLK_ENABLE)
    begin
      rd_mux = {4'h0, blk_en_q};
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_q <= port_regs_pkg::RD_ZERO;
    end
    else
    begin
      rdata_q <= req.rd ? rd_mux : port_regs_pkg::RD_ZERO;
    end
  end

  assign rdata = rdata_q;
  assign port_irq = port_irq_q;
  assign power_event_pin = power_event_q;
  assign irq = irq_q;

endmodule : port_wake_and_irq_regs

// [design/port_regs_pkg.sv]
package port_regs_pkg;

  // port slices, numbered 1 to 3 in the upper address nibble
  localparam int NUM_PORTS = 3;
  // index of the MAC port (port 3), which has no integrated PHY
  localparam int MAC_PORT_IDX = 2;

  // address split: port nibble, must-be-zero nibble, byte offset
  localparam int ADDR_W = 16;
  localparam int PORT_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int OFS_LSB = 0;
  localparam logic [3:0] PAGE_ZERO = 4'h0;
  localparam logic [3:0] GLOBAL_PORT = 4'h0;

  // per-port byte offsets
  localparam logic [7:0] OFS_C1_TAG_LOW = 8'h05;
  localparam logic [7:0] OFS_C2_TAG_HIGH = 8'h06;
  localparam logic [7:0] OFS_C2_TAG_LOW = 8'h07;
  localparam logic [7:0] OFS_C1_TYPE_HI = 8'h08;
  localparam logic [7:0] OFS_C1_TYPE_LO = 8'h09;
  localparam logic [7:0] OFS_C2_TYPE_HI = 8'h0A;
  localparam logic [7:0] OFS_C2_TYPE_LO = 8'h0B;
  localparam logic [7:0] OFS_WAKE_LATCH = 8'h13;
  localparam logic [7:0] OFS_WAKE_ENABLE = 8'h17;
  localparam logic [7:0] OFS_IRQ_SUMMARY = 8'h1B;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1F;

  // block interrupt registers in the global page
  localparam logic [7:0] OFS_BLK_STATUS = 8'hE0;
  localparam logic [7:0] OFS_BLK_CLEAR = 8'hE1;
  localparam logic [7:0] OFS_BLK_ENABLE = 8'hE2;

  // reset values
  localparam logic [7:0] RST_C1_TAG_LOW = 8'h02;
  localparam logic [7:0] RST_C2_TAG_HIGH = 8'h40;
  localparam logic [7:0] RST_C2_TAG_LOW = 8'h03;
  localparam logic [15:0] RST_ETHERTYPE = 16'h88B5;
  localparam logic [2:0] RST_FIELD3 = 3'h0;
  localparam logic [3:0] RST_FIELD4 = 4'h0;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // wake latch / wake enable bit positions
  localparam int WAKE_MAGIC_BIT = 2;
  localparam int WAKE_LINK_BIT = 1;
  localparam int WAKE_ENERGY_BIT = 0;

  // port interrupt summary / mask bit positions
  localparam int IRQ_PTP_BIT = 2;
  localparam int IRQ_PHY_BIT = 1;
  localparam int IRQ_ACL_BIT = 0;

  // block status bit of the power event pin (ports use bits 2:0)
  localparam int BLK_POWER_BIT = 3;

  // register bus request, one cycle per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // detection pulses and pending levels from one port
  typedef struct packed {
    logic magic_det;
    logic link_up_det;
    logic energy_det;
    logic ptp_pending;
    logic phy_pending;
    logic acl_hit;
  } port_ev_s;

endpackage : port_regs_pkg

// [dv/port_wake_and_irq_regs_chk.sv]
`timescale 1ns/1ps
module port_wake_and_irq_regs_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire port_regs_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire port_regs_pkg::port_ev_s [port_regs_pkg::NUM_PORTS-1:0] port_ev,
  input wire logic [port_regs_pkg::NUM_PORTS-1:0] port_irq,
  input wire logic power_event_pin,
  input wire logic irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // any wake detection pulse on any port
  logic det_any;
  always_comb
  begin
    det_any = 1'b0;
    for (int i = 0; i < port_regs_pkg::NUM_PORTS; i++)
      det_any |= port_ev[i].magic_det | port_ev[i].link_up_det
        | port_ev[i].energy_det;
  end

  // read data stand for one cycle only
  rd_idle_zero_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data seen outside a read answer");
  bad_page_a: assert property (req.rd && req.addr[11:8] != 4'h0
    |=> rdata == 8'h00) else $error("unmapped page read not zero");
  mac_summary_a: assert property (req.rd && req.addr == 16'h301B
    |=> rdata[2:1] == 2'b00) else $error("mac port summary shows phy bits");
  mac_wake_a: assert property (req.rd && req.addr == 16'h3013
    |=> rdata[1:0] == 2'b00) else $error("mac port wake shows phy events");
  resv_bits_a: assert property (req.rd
    && req.addr[7:0] inside {8'h13, 8'h17, 8'h1B}
    |=> rdata[7:3] == 5'h00) else $error("reserved bits read nonzero");
  // the pin only moves after a detection or a software write
  pin_rise_a: assert property ($rose(power_event_pin)
    |-> $past(det_any, 2) || $past(req.wr, 2))
    else $error("power event pin rose without a cause");
  pin_fall_a: assert property ($fell(power_event_pin)
    |-> $past(req.wr, 2)) else $error("power event pin fell without write");
  irq_fall_a: assert property ($fell(irq) |-> $past(req.wr, 2))
    else $error("interrupt fell without a write");
  acl_irq_a: assert property ($rose(port_irq[0])
    |-> $past(port_ev[0].acl_hit, 2) || $past(port_ev[0].ptp_pending)
    || $past(port_ev[0].phy_pending) || $past(req.wr, 2))
    else $error("port interrupt rose without a cause");
endmodule : port_wake_and_irq_regs_chk

// [dv/port_wake_and_irq_regs_tb_top.sv]
`timescale 1ns/1ps
module port_wake_and_irq_regs_tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  port_regs_pkg::reg_req_s req = '0;
  logic [7:0] rdata;
  port_regs_pkg::port_ev_s [port_regs_pkg::NUM_PORTS-1:0] port_ev = '0;
  logic [port_regs_pkg::NUM_PORTS-1:0] port_irq;
  logic power_event_pin;
  logic irq;
  int fail_count = 0;
  int n_compared = 0;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  port_wake_and_irq_regs i_port_wake_and_irq_regs (.clk_sys(clk_sys),
    .srst(srst), .req(req), .rdata(rdata), .port_ev(port_ev),
    .port_irq(port_irq), .power_event_pin(power_event_pin), .irq(irq));

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one-cycle strobes, an idle edge after each so no signal is set twice
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // answer sampled at the edge that closes its only valid cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(posedge clk_sys);
    chk($sformatf("read %h", a), rdata, e);
  endtask : rd

  task automatic ev(input int p, input port_regs_pkg::port_ev_s v);
    port_ev[p] <= v;
    @(posedge clk_sys);
    port_ev[p] <= '0;
    @(posedge clk_sys);
  endtask : ev

  task automatic pin(input logic [7:0] e);
    chk("power_event_pin", {7'h00, power_event_pin}, e);
  endtask : pin

  task automatic t_reset();
    logic [7:0] ofs [11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
      8'h0B, 8'h13, 8'h17, 8'h1B, 8'h1F};
    logic [7:0] exp [11] = '{8'h02, 8'h40, 8'h03, 8'h88, 8'hB5, 8'h88,
      8'hB5, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int p = 1; p <= 3; p++)
      for (int i = 0; i < 11; i++)
        rd({4'(p), 4'h0, ofs[i]}, exp[i]);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask : t_reset

  task automatic t_rw();
    wr(16'h2005, 8'h5A);
    wr(16'h2006, 8'hA5);
    wr(16'h2007, 8'h3C);
    wr(16'h200A, 8'h12);
    wr(16'h201B, 8'hFF);
    rd(16'h2005, 8'h5A);
    rd(16'h2006, 8'hA5);
    rd(16'h2007, 8'h3C);
    rd(16'h200A, 8'h12);
    rd(16'h200B, 8'hB5);
    rd(16'h201B, 8'h00);
    rd(16'h1005, 8'h02);
    rd(16'h1105, 8'h00);
  endtask : t_rw

  task automatic t_wake();
    wr(16'h1017, 8'h04);
    ev(0, 6'h20);
    rd(16'h1013, 8'h04);
    pin(8'h01);
    wr(16'h1013, 8'h04);
    rd(16'h1013, 8'h00);
    pin(8'h00);
    ev(1, 6'h18);
    rd(16'h2013, 8'h03);
    pin(8'h00);
    wr(16'h2017, 8'h03);
    rd(16'h2017, 8'h03);
    pin(8'h01);
    wr(16'h2013, 8'h03);
    ev(2, 6'h18);
    rd(16'h3013, 8'h00);
    wr(16'h1017, 8'h00);
    ev(0, 6'h20);
    rd(16'h1013, 8'h04);
    pin(8'h00);
    wr(16'h1013, 8'h04);
  endtask : t_wake

  task automatic t_irq();
    port_ev[0] <= 6'h06;
    port_ev[2] <= 6'h06;
    @(posedge clk_sys);
    rd(16'h101B, 8'h06);
    rd(16'h301B, 8'h00);
    chk("port_irq", {5'h00, port_irq}, 8'h01);
    wr(16'h101F, 8'h06);
    rd(16'h101B, 8'h06);
    chk("port_irq", {5'h00, port_irq}, 8'h00);
    port_ev[0] <= '0;
    port_ev[2] <= '0;
    @(posedge clk_sys);
    ev(0, 6'h01);
    rd(16'h101B, 8'h01);
    wr(16'h101B, 8'h00);
    rd(16'h101B, 8'h01);
    chk("port_irq", {5'h00, port_irq}, 8'h01);
    wr(16'h101F, 8'h07);
    rd(16'h101B, 8'h00);
  endtask : t_irq

  // sticky block status: port 1 forwarded and power event rose
  task automatic t_blk();
    rd(16'h00E0, 8'h09);
    wr(16'h00E2, 8'h0F);
    rd(16'h00E2, 8'h0F);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(16'h00E1, 8'h0F);
    rd(16'h00E0, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
  endtask : t_blk

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_rw();
    t_wake();
    t_irq();
    t_blk();
    final_report();
  end

  // guard against a hung run
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
endmodule : port_wake_and_irq_regs_tb_top

bind port_wake_and_irq_regs port_wake_and_irq_regs_chk
  i_port_wake_and_irq_regs_chk (.clk_sys(clk_sys), .srst(srst), .req(req),
  .rdata(rdata), .port_ev(port_ev), .port_irq(port_irq),
  .power_event_pin(power_event_pin), .irq(irq));
